//--- hw/dor_brake_pwm.sv
module dor_brake_pwm
    import dor_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] freq_hz,
    input wire logic [7:0] duty_pct,
    output logic pwm
);

    logic [24:0] phase_q;
    logic pwm_q;

    // out-of-range settings are clamped rather than refused
    wire [15:0] freq = (freq_hz < PWM_FREQ_MIN) ? PWM_FREQ_MIN :
                       (freq_hz > PWM_FREQ_MAX) ? PWM_FREQ_MAX : freq_hz;
    wire [7:0] duty = (duty_pct < PWM_DUTY_MIN) ? PWM_DUTY_MIN :
                      (duty_pct > PWM_DUTY_MAX) ? PWM_DUTY_MAX : duty_pct;
    // phase accumulator avoids a divider: one wrap per period
    wire [24:0] phase_sum = phase_q + {9'h000, freq};
    wire [24:0] phase_d = (phase_sum >= 25'(CLK_HZ)) ? phase_sum - 25'(CLK_HZ) : phase_sum;
    // operands widened first so the product cannot wrap before it is sized
    wire [25:0] thresh = {18'h00000, duty} * {8'h00, CLK_PER_PCT};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= 25'h0000000;
            pwm_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            pwm_q <= ({1'b0, phase_d} < thresh); // [RULE13]
        end
    end

    assign pwm = pwm_q;

endmodule

//--- hw/dor_pkg.sv
// Notes on behaviour
// [RULE1] routing acts only while enable equals one
// [RULE2] high byte source, low byte gating bit
// [RULE3] one sixteen bit routing word per output
// [RULE4] entry one soft pwm, then outputs one..n
// [RULE5] soft pwm 2 kHz, others 500 Hz
// [RULE6] source passes only while gating bit active
// [RULE7] bit seven inverts the gating bit sense
// [RULE8] software writes deactivation value to disable output
// [RULE9] selector 00 high, 01 low
// [RULE10] selectors 02..08 encoder count divided 1..64
// [RULE11] selectors 09..0f position divided 1..64
// [RULE12] divider one: one pulse per increment
// [RULE13] selector 10 brake pwm, 11 inverted
// [RULE14] software gates brake pwm with bit zero
// [RULE15] undocumented selectors drive output low
// [RULE16] per output counter paces divided pulses
package dor_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int NUM_OUT = 3;
    localparam int CLK_HZ = 20_000_000;
    localparam int SPWM_MAX_HZ = 2000;
    localparam int OUT_MAX_HZ = 500;
    // a full period at the limit is one high and one low half
    localparam int SPWM_HOLD_CYCLES = CLK_HZ / (2 * SPWM_MAX_HZ);
    localparam int OUT_HOLD_CYCLES = CLK_HZ / (2 * OUT_MAX_HZ);
    localparam int PCT_FULL = 100;
    localparam logic [17:0] CLK_PER_PCT = 18'(CLK_HZ / PCT_FULL);
    localparam logic [15:0] PWM_FREQ_MIN = 16'h0032;
    localparam logic [15:0] PWM_FREQ_MAX = 16'h4e20;
    localparam logic [7:0] PWM_DUTY_MIN = 8'h02;
    localparam logic [7:0] PWM_DUTY_MAX = 8'h64;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_ROUTE0 = 8'h08;
    localparam logic [7:0] ADDR_PWM_FREQ = 8'h14;
    localparam logic [7:0] ADDR_PWM_DUTY = 8'h18;
    localparam logic [7:0] ADDR_OUT_STATE = 8'h1c;
    localparam logic [7:0] ROUTE_STRIDE = 8'h04;

    localparam logic [15:0] ROUTE_OFF = 16'h0fff;
    localparam logic [15:0] ROUTE_RESET = ROUTE_OFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] PWM_FREQ_RESET = 16'h03e8;
    localparam logic [7:0] PWM_DUTY_RESET = 8'h32;
    // plain outputs follow the control word from this bit upward
    localparam int CTRL_OUT_BASE = 16;

    // ----------------------------------------------------------------
    // source selectors
    // ----------------------------------------------------------------
    localparam logic [7:0] SEL_HIGH = 8'h00;
    localparam logic [7:0] SEL_LOW = 8'h01;
    localparam logic [7:0] SEL_ENC_FIRST = 8'h02;
    localparam logic [7:0] SEL_ENC_LAST = 8'h08;
    localparam logic [7:0] SEL_POS_FIRST = 8'h09;
    localparam logic [7:0] SEL_POS_LAST = 8'h0f;
    localparam logic [7:0] SEL_PWM = 8'h10;
    localparam logic [7:0] SEL_PWM_INV = 8'h11;

    typedef struct packed {
        logic [7:0] src_sel;
        logic gate_inv;
        logic [6:0] gate_idx;
    } dor_route_t;

    typedef struct packed {
        logic [31:0] raw_encoder_count;
        logic [31:0] actual_position_value;
    } dor_motion_t;

    typedef enum logic [1:0] {
        PG_IDLE = 2'b00,
        PG_HIGH = 2'b01,
        PG_LOW = 2'b10
    } dor_pg_state_t;

endpackage

//--- hw/dor_pulse_gen.sv
module dor_pulse_gen
    import dor_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic [31:0] value,
    input wire logic [2:0] div_shift,
    input wire logic [15:0] hold_cycles,
    output logic pulse
);

    logic [31:0] prev_q;
    logic [5:0] frac_q;
    logic [5:0] frac_d;
    logic [17:0] owed_q;
    logic [17:0] owed_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    dor_pg_state_t state_q;
    dor_pg_state_t state_d;
    logic pulse_q;
    logic pulse_d;

    // ----------------------------------------------------------------
    // increment counting
    // ----------------------------------------------------------------
    // movement in either direction counts; a huge jump saturates
    wire [31:0] diff = value - prev_q;
    wire [31:0] mag = diff[31] ? (~diff + 32'h0000_0001) : diff;
    wire [15:0] steps = (mag[31:16] != 16'h0000) ? 16'hffff : mag[15:0];
    wire [16:0] sum = {1'b0, steps} + {11'h000, frac_q};
    wire [16:0] new_pulses = sum >> div_shift; // [RULE10] [RULE11] [RULE12]
    wire [16:0] frac_mask = (17'h00001 << div_shift) - 17'h00001;
    wire take = (state_q == PG_IDLE) && (owed_q != 18'h00000);
    wire [18:0] owed_sum = {1'b0, owed_q} + {2'b00, new_pulses} - {18'h00000, take};

    assign frac_d = 6'(sum & frac_mask);
    assign owed_d = owed_sum[18] ? 18'h3ffff : owed_sum[17:0];

    // ----------------------------------------------------------------
    // pacing: each pulse is one hold high and one hold low
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        pulse_d = pulse_q;
        case (state_q)
            PG_IDLE:
            begin
                if (take)
                begin
                    state_d = PG_HIGH; // [RULE16]
                    pulse_d = 1'b1;
                    cnt_d = hold_cycles - 16'h0001;
                end
            end
            PG_HIGH:
            begin
                if (cnt_q == 16'h0000)
                begin
                    state_d = PG_LOW;
                    pulse_d = 1'b0;
                    cnt_d = hold_cycles - 16'h0001;
                end
                else
                begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            PG_LOW:
            begin
                if (cnt_q == 16'h0000)
                begin
                    state_d = PG_IDLE;
                end
                else
                begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default:
            begin
                state_d = PG_IDLE;
                pulse_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev_q <= 32'h0000_0000;
            frac_q <= 6'h00;
            owed_q <= 18'h00000;
            cnt_q <= 16'h0000;
            state_q <= PG_IDLE;
            pulse_q <= 1'b0;
        end
        else
        begin
            // previous value tracks always, so enabling never sees a stale jump
            prev_q <= value;
            frac_q <= en ? frac_d : 6'h00;
            owed_q <= en ? owed_d : 18'h00000;
            cnt_q <= en ? cnt_d : 16'h0000;
            state_q <= en ? state_d : PG_IDLE;
            pulse_q <= en ? pulse_d : 1'b0;
        end
    end

    assign pulse = pulse_q;

endmodule

//--- hw/dor_top.sv
module dor_top
    import dor_pkg::*;
#(
    parameter int SPWM_HOLD_CYC = SPWM_HOLD_CYCLES,
    parameter int OUT_HOLD_CYC = OUT_HOLD_CYCLES
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire dor_motion_t motion,
    output logic [NUM_OUT-1:0] dout
);

    logic route_enable_q;
    logic [31:0] ctrl_q;
    logic [15:0] route_q [NUM_OUT];
    logic [15:0] pwm_freq_q;
    logic [7:0] pwm_duty_q;
    logic [31:0] rdata_q;
    logic [NUM_OUT-1:0] out_q;
    logic brake_pwm;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire hit_enable = (reg_addr == ADDR_ENABLE);
    wire hit_ctrl = (reg_addr == ADDR_CTRL);
    wire hit_freq = (reg_addr == ADDR_PWM_FREQ);
    wire hit_duty = (reg_addr == ADDR_PWM_DUTY);
    wire hit_state = (reg_addr == ADDR_OUT_STATE);
    wire [7:0] route_off = reg_addr - ADDR_ROUTE0;
    wire [7:0] route_sel = route_off >> 2;
    wire hit_route = (reg_addr >= ADDR_ROUTE0) && (route_off[1:0] == 2'b00) &&
                     (route_sel < 8'(NUM_OUT));

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_enable)
        begin
            rd_mux = {31'h0000_0000, route_enable_q};
        end
        else if (hit_ctrl)
        begin
            rd_mux = ctrl_q;
        end
        else if (hit_route)
        begin
            rd_mux = {16'h0000, route_q[route_sel[1:0]]};
        end
        else if (hit_freq)
        begin
            rd_mux = {16'h0000, pwm_freq_q};
        end
        else if (hit_duty)
        begin
            rd_mux = {24'h000000, pwm_duty_q};
        end
        else if (hit_state)
        begin
            rd_mux = {{(32-NUM_OUT){1'b0}}, out_q};
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            route_enable_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
            pwm_freq_q <= PWM_FREQ_RESET;
            pwm_duty_q <= PWM_DUTY_RESET;
        end
        else if (reg_wr)
        begin
            if (hit_enable)
            begin
                route_enable_q <= reg_wdata[0];
            end
            if (hit_ctrl)
            begin
                ctrl_q <= reg_wdata;
            end
            if (hit_freq)
            begin
                pwm_freq_q <= reg_wdata[15:0];
            end
            if (hit_duty)
            begin
                pwm_duty_q <= reg_wdata[7:0];
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // shared brake pwm source
    // ----------------------------------------------------------------
    dor_brake_pwm u_pwm (
        .clk(clk),
        .arst_n(arst_n),
        .freq_hz(pwm_freq_q),
        .duty_pct(pwm_duty_q),
        .pwm(brake_pwm)
    );

    // ----------------------------------------------------------------
    // per output routing
    // ----------------------------------------------------------------
    // entry 0 is the soft pwm output, entry k the output k
    for (genvar i = 0; i < NUM_OUT; i++)
    begin : g_out
        localparam int HOLD = (i == 0) ? SPWM_HOLD_CYC : OUT_HOLD_CYC;
        localparam logic [15:0] HOLD16 = 16'(HOLD);

        logic kind_enc_q;
        logic [15:0] lim_cnt_q;
        logic pulse;

        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                route_q[i] <= ROUTE_RESET;
            end
            else if (reg_wr && hit_route && (route_sel[1:0] == 2'(i)))
            begin
                route_q[i] <= reg_wdata[15:0]; // [RULE3] [RULE4]
            end
        end

        wire dor_route_t rw = route_q[i];
        wire [7:0] sel = rw.src_sel; // [RULE2]
        wire is_enc = (sel >= SEL_ENC_FIRST) && (sel <= SEL_ENC_LAST);
        wire is_pos = (sel >= SEL_POS_FIRST) && (sel <= SEL_POS_LAST);
        wire [7:0] enc_rel = sel - SEL_ENC_FIRST;
        wire [7:0] pos_rel = sel - SEL_POS_FIRST;
        wire [2:0] div_shift = is_enc ? enc_rel[2:0] : pos_rel[2:0];
        wire [31:0] mval = is_enc ? motion.raw_encoder_count : motion.actual_position_value;
        // indices above 31 point past the control word and read as zero
        wire gate_raw = (rw.gate_idx[6:5] == 2'b00) && ctrl_q[rw.gate_idx[4:0]];
        wire gate_on = gate_raw ^ rw.gate_inv; // [RULE7]
        wire active = route_enable_q && (route_q[i] != ROUTE_OFF); // [RULE1] [RULE8]
        // a switch between encoder and position drops the counter for one cycle
        wire pg_en = active && (is_enc || is_pos) && (kind_enc_q == is_enc);

        wire src_level = (sel == SEL_HIGH) ? 1'b1 : // [RULE9]
                         (sel == SEL_LOW) ? 1'b0 :
                         (sel == SEL_PWM) ? brake_pwm : // [RULE13]
                         (sel == SEL_PWM_INV) ? ~brake_pwm :
                         (is_enc || is_pos) ? pulse : 1'b0; // [RULE15]
        wire plain = (i == 0) ? 1'b0 : ctrl_q[CTRL_OUT_BASE + i - 1];
        wire target = active ? (src_level & gate_on) : plain; // [RULE6]

        dor_pulse_gen u_pg (
            .clk(clk),
            .arst_n(arst_n),
            .en(pg_en),
            .value(mval),
            .div_shift(div_shift),
            .hold_cycles(HOLD16),
            .pulse(pulse)
        );

        // rate limit: after any change the level holds for a half period
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                kind_enc_q <= 1'b0;
                lim_cnt_q <= 16'h0000;
                out_q[i] <= 1'b0;
            end
            else
            begin
                kind_enc_q <= is_enc;
                if (lim_cnt_q != 16'h0000)
                begin
                    lim_cnt_q <= lim_cnt_q - 16'h0001;
                end
                else if (target != out_q[i])
                begin
                    out_q[i] <= target; // [RULE5]
                    lim_cnt_q <= HOLD16 - 16'h0001;
                end
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign dout = out_q;

endmodule

//--- testbench/dor_route_chk.sv
module dor_route_chk
    import dor_pkg::*;
#(
    parameter int SPWM_HOLD_CYC = 4,
    parameter int OUT_HOLD_CYC = 8
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire dor_motion_t motion,
    input wire logic [NUM_OUT-1:0] dout
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // shadow of the software view
    // ----------------------------------------------------------------
    logic en_q;
    logic [31:0] ctrl_q;
    logic [15:0] route_q [NUM_OUT];
    logic [NUM_OUT-1:0] dout_q;
    logic [NUM_OUT-1:0] tgt;
    logic [NUM_OUT-1:0] known;
    logic [NUM_OUT-1:0] tgt_q;
    int gap_q [NUM_OUT];
    int calm_q [NUM_OUT];

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
            route_q <= '{default: ROUTE_RESET};
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_ENABLE)
                en_q <= reg_wdata[0];
            if (reg_addr == ADDR_CTRL)
                ctrl_q <= reg_wdata;
            for (int k = 0; k < NUM_OUT; k++)
                if (reg_addr == ADDR_ROUTE0 + 8'(k) * ROUTE_STRIDE)
                    route_q[k] <= reg_wdata[15:0];
        end
    end

    // encoder, position and pwm sources are not predicted here
    always_comb
    begin
        for (int k = 0; k < NUM_OUT; k++)
        begin
            known[k] = 1'b1;
            tgt[k] = ((route_q[k][6:0] < 7'h20) && ctrl_q[route_q[k][4:0]]) ^ route_q[k][7];
            if (!en_q || route_q[k] == ROUTE_OFF)
                tgt[k] = (k == 0) ? 1'b0 : ctrl_q[CTRL_OUT_BASE + k - 1];
            else if (route_q[k][15:8] != SEL_HIGH)
            begin
                known[k] = (route_q[k][15:8] == SEL_LOW) || (route_q[k][15:8] > SEL_PWM_INV);
                tgt[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dout_q <= '0;
            tgt_q <= '0;
            gap_q <= '{default: 100000};
            calm_q <= '{default: 0};
        end
        else
        begin
            dout_q <= dout;
            tgt_q <= tgt;
            for (int k = 0; k < NUM_OUT; k++)
            begin
                gap_q[k] <= (dout[k] != dout_q[k]) ? 1 : gap_q[k] + 1;
                calm_q[k] <= (!known[k] || tgt[k] != tgt_q[k]) ? 0 : calm_q[k] + 1;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_spwm_rate: assert property ((dout[0] != dout_q[0]) |-> gap_q[0] >= SPWM_HOLD_CYC)
        else $error("soft pwm output changed too soon");
    a_out1_rate: assert property ((dout[1] != dout_q[1]) |-> gap_q[1] >= OUT_HOLD_CYC)
        else $error("output one changed too soon");
    a_out2_rate: assert property ((dout[2] != dout_q[2]) |-> gap_q[2] >= OUT_HOLD_CYC)
        else $error("output two changed too soon");
    // the level is compared with last cycle's target, as the output is registered
    a_settle_spwm: assert property (calm_q[0] >= SPWM_HOLD_CYC + 6 |-> dout[0] == tgt_q[0])
        else $error("soft pwm output level wrong");
    a_settle_out1: assert property (calm_q[1] >= OUT_HOLD_CYC + 6 |-> dout[1] == tgt_q[1])
        else $error("output one level wrong");
    a_settle_out2: assert property (calm_q[2] >= OUT_HOLD_CYC + 6 |-> dout[2] == tgt_q[2])
        else $error("output two level wrong");
    a_enable_rdback: assert property (reg_rd && reg_addr == ADDR_ENABLE
        |=> reg_rdata == {31'h0, $past(en_q)})
        else $error("enable read back wrong");
    a_ctrl_rdback: assert property (reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata == $past(ctrl_q))
        else $error("control word read back wrong");
    a_route_rdback: assert property (reg_rd && reg_addr == ADDR_ROUTE0 + ROUTE_STRIDE
        |=> reg_rdata == {16'h0, $past(route_q[1])})
        else $error("route word read back wrong");
endmodule

//--- testbench/dor_top_test.sv
module dor_top_test
    import dor_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // short holds keep the pulse scenarios brief
    // ----------------------------------------------------------------
    localparam int SH = 4;
    localparam int OH = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    dor_motion_t motion = '0;
    logic [NUM_OUT-1:0] dout;
    logic last;
    int err_count = 0;
    int samples_checked = 0;
    int rises;

    always #25 clk = ~clk;

    dor_top #(.SPWM_HOLD_CYC(SH), .OUT_HOLD_CYC(OH)) dor_top_inst (
        .clk(clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .motion(motion),
        .dout(dout)
    );

    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata);
    endtask

    // waits out two full holds so a delayed change has landed
    task automatic step(input int k, input logic [15:0] rw, input logic [31:0] cw, input logic e);
        wr(ADDR_ROUTE0 + 8'(k) * ROUTE_STRIDE, {16'h0, rw});
        wr(ADDR_CTRL, cw);
        repeat (2 * OH + 8) @(posedge clk);
        #1;
        chk("routed output", {31'h0, e}, {31'h0, dout[k]});
    endtask

    // dropping enable clears any pulses still owed from the last selector
    task automatic pulses(input logic [7:0] sel, input int incs, input int exp);
        wr(ADDR_ENABLE, 32'h0);
        wr(ADDR_ROUTE0 + ROUTE_STRIDE, {16'h0, sel, 8'h05});
        wr(ADDR_ENABLE, 32'h1);
        rises = 0;
        last = dout[1];
        for (int i = 0; i < incs + 40 * exp + 40; i++)
        begin
            @(posedge clk);
            if (dout[1] && !last)
                rises++;
            last = dout[1];
            if (i < incs)
            begin
                if (sel < SEL_POS_FIRST)
                    motion.raw_encoder_count <= motion.raw_encoder_count + 32'h1;
                else
                    motion.actual_position_value <= motion.actual_position_value - 32'h1;
            end
        end
        chk("pulse count", 32'(exp), 32'(rises));
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_ENABLE, 32'h0);
        rd(ADDR_CTRL, CTRL_RESET);
        for (int k = 0; k < NUM_OUT; k++)
            rd(ADDR_ROUTE0 + 8'(k) * ROUTE_STRIDE, {16'h0, ROUTE_RESET});
        rd(ADDR_PWM_FREQ, {16'h0, PWM_FREQ_RESET});
        rd(ADDR_PWM_DUTY, {24'h0, PWM_DUTY_RESET});
        rd(8'h20, 32'h0);
        wr(ADDR_ROUTE0 + ROUTE_STRIDE, 32'hffff_0405);
        rd(ADDR_ROUTE0 + ROUTE_STRIDE, 32'h0000_0405);
        step(1, 16'h0005, 32'h0001_0000, 1'b1);
        step(0, 16'h0000, 32'h0000_0001, 1'b0);
        wr(ADDR_ENABLE, 32'h1);
        step(0, 16'h0000, 32'h0000_0001, 1'b1);
        step(1, 16'h0005, 32'h0000_0020, 1'b1);
        step(1, 16'h0005, 32'h0000_0000, 1'b0);
        step(1, 16'h0085, 32'h0000_0000, 1'b1);
        step(1, 16'h0085, 32'h0000_0020, 1'b0);
        step(1, 16'h0105, 32'h0000_0020, 1'b0);
        step(1, 16'h2005, 32'h0000_0020, 1'b0);
        step(1, 16'h0025, 32'hffff_ffff, 1'b0);
        step(2, 16'h0fff, 32'h0002_0000, 1'b1);
        step(1, 16'h0fff, 32'h0001_0000, 1'b1);
        rd(ADDR_OUT_STATE, 32'h0000_0002);
        wr(ADDR_PWM_DUTY, 32'h0000_0064);
        step(1, 16'h1000, 32'h0000_0001, 1'b1);
        step(1, 16'h1100, 32'h0000_0001, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0020);
        for (int s = 2; s < 16; s++)
            pulses(8'(s), 2 << ((s - 2) % 7), 2);
        complete_run();
    end
endmodule

bind dor_top dor_route_chk #(
    .SPWM_HOLD_CYC(SPWM_HOLD_CYC),
    .OUT_HOLD_CYC(OUT_HOLD_CYC)
) dor_route_chk_inst (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .motion(motion),
    .dout(dout)
);
